// ---- pkg/fcl_pkg.sv ----
// constants and types for the flash command latch block
package fcl_pkg;

  // opcodes decoded by the block
  localparam logic [7:0] FCL_WRITE_ARM_CMD         = 8'h06;
  localparam logic [7:0] FCL_WRITE_DISARM_CMD      = 8'h04;
  localparam logic [7:0] FCL_FACTORY_BOOST_ARM_CMD = 8'h41;
  localparam logic [7:0] FCL_IDENTITY_READ_CMD     = 8'h9F;
  localparam logic [7:0] FCL_QUAD_IDENTITY_CMD     = 8'hAF;
  localparam logic [7:0] FCL_MAKER_DEVICE_ID_CMD   = 8'h90;
  // wake and legacy signature share one opcode
  localparam logic [7:0] FCL_WAKE_CMD              = 8'hAB;
  localparam logic [7:0] FCL_DEEP_SLEEP_CMD        = 8'hB9;
  localparam logic [7:0] FCL_SOFT_RESTART_ARM_CMD  = 8'h66;
  localparam logic [7:0] FCL_SOFT_RESTART_CMD      = 8'h99;
  localparam logic [7:0] FCL_STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] FCL_BLOCK_WIPE_CMD        = 8'hD8;
  localparam logic [7:0] FCL_CHIP_WIPE_A_CMD       = 8'h60;
  localparam logic [7:0] FCL_CHIP_WIPE_B_CMD       = 8'hC7;
  localparam logic [7:0] FCL_SUSPEND_A_CMD         = 8'h75;
  localparam logic [7:0] FCL_SUSPEND_B_CMD         = 8'hB0;
  localparam logic [7:0] FCL_SECURITY_WRITE_CMD    = 8'h2F;
  localparam logic [7:0] FCL_PROTECT_SELECT_CMD    = 8'h68;
  localparam logic [7:0] FCL_GANG_LOCK_CMD         = 8'h7E;
  localparam logic [7:0] FCL_GANG_UNLOCK_CMD       = 8'h98;
  localparam logic [7:0] FCL_LOCK_WRITE_CMD        = 8'h2C;
  localparam logic [7:0] FCL_PROT_BIT_PROGRAM_CMD  = 8'hE3;
  localparam logic [7:0] FCL_PROT_BIT_ERASE_CMD    = 8'hE4;
  localparam logic [7:0] FCL_DYN_PROTECT_WRITE_CMD = 8'hE1;

  // link clock counts within a frame
  localparam logic [5:0] FCL_SPI_OP_CLKS    = 6'h08;
  localparam logic [5:0] FCL_QUAD_OP_CLKS   = 6'h02;
  localparam logic [5:0] FCL_SPI_ADDR_CLKS  = 6'h18;
  localparam logic [5:0] FCL_QUAD_ADDR_CLKS = 6'h06;
  localparam logic [5:0] FCL_SPI_BYTE_CLKS  = 6'h08;
  localparam logic [5:0] FCL_QUAD_BYTE_CLKS = 6'h02;
  localparam logic [5:0] FCL_CNT_MAX        = 6'h3F;

  // output enables, active low
  localparam logic [3:0] FCL_OE_N_IDLE = 4'hF;
  localparam logic [3:0] FCL_OE_N_SPI  = 4'hD;
  localparam logic [3:0] FCL_OE_N_QUAD = 4'h0;

  // wake delays, reference clock 50 MHz
  localparam int FCL_REF_CLK_MHZ               = 50;
  localparam int FCL_WAKE_DELAY_PLAIN_NS       = 3000;
  localparam int FCL_WAKE_DELAY_SIGNATURE_NS   = 1800;
  localparam int FCL_WAKE_DELAY_PLAIN_CYC      =
    (FCL_WAKE_DELAY_PLAIN_NS * FCL_REF_CLK_MHZ + 999) / 1000;
  localparam int FCL_WAKE_DELAY_SIGNATURE_CYC  =
    (FCL_WAKE_DELAY_SIGNATURE_NS * FCL_REF_CLK_MHZ + 999) / 1000;
  localparam int FCL_WAKE_CNT_W = 12;

  // device state carried into the link domain
  typedef struct packed {
    logic busy;
    logic deep_sleep;
    logic quad;
  } fcl_link_flags_t;

  typedef enum logic [2:0] {
    FCL_OUT_NONE,
    FCL_OUT_IDENT,
    FCL_OUT_QIDENT,
    FCL_OUT_MAKER,
    FCL_OUT_SIG
  } fcl_out_mode_t;

endpackage : fcl_pkg

// ---- core/fcl_sync.sv ----
// two flip-flop synchroniser, one bit per lane
`timescale 1ns/100ps
`default_nettype none
module fcl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  // lanes
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule : fcl_sync
`default_nettype wire

// ---- core/fcl_cmd_core.sv ----
// command latch, identity output and wake logic of a serial flash
// Operation
// - restart runs only right after its arm
// - address zero maker first, one device first
// - maker/device bytes alternate, MSB first
// - write arm sets write enable latch
// - opcodes in 8 single or 2 quad clocks
// - write disarm clears write enable latch
// - listed commands and clear pin clear latch
// - factory mode refuses suspend
// - factory flag clears on op or restart
// - identity read gives three bytes, 24 bits
// - no identity decode while array busy
// - identity read only in single-line mode
// - wake from deep sleep takes plain delay
// - clear pin low leaves deep sleep
// - wake, signature accepted in deep sleep
// - signature byte repeats while clocks continue
// - signature wake uses signature delay
// - quad identity streams three bytes continuously
// - change commands ignored without write latch
`timescale 1ns/100ps
`default_nettype none
module fcl_cmd_core #(
  // identity values below are arbitrary
  parameter logic [7:0] MAKER_ID      = 8'h5A,
  parameter logic [7:0] MEM_TYPE      = 8'h3C,
  parameter logic [7:0] MEM_DENSITY   = 8'h4E,
  parameter logic [7:0] DEVICE_ID     = 8'h4D,
  parameter logic [7:0] SIGNATURE_ID  = 8'h4D,
  // array write opcodes
  parameter logic [7:0] PAGE_WRITE_CMD      = 8'h02,
  parameter logic [7:0] QUAD_PAGE_WRITE_CMD = 8'h38,
  parameter logic [7:0] SMALL_WIPE_CMD      = 8'h20,
  parameter logic [7:0] HALF_BLOCK_WIPE_CMD = 8'h52
) (
  // reference clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // serial link
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] sio_in,
  output logic      [3:0] sio_out,
  output logic      [3:0] sio_oe_n_out,
  // hardware clear pin
  input  wire logic       clear_n_in,
  // array engine and mode
  input  wire logic       array_busy_in,
  input  wire logic       array_done_in,
  input  wire logic       quad_mode_in,
  output logic            array_start_out,
  output logic      [7:0] array_cmd_out,
  output logic            suspend_out,
  output logic            soft_restart_out,
  // device state
  output logic            write_enable_latch_out,
  output logic            factory_boost_out,
  output logic            deep_sleep_out,
  output logic            ready_out
);

  localparam int AST_WAKE_PLAIN = fcl_pkg::FCL_WAKE_DELAY_PLAIN_CYC;
  localparam int AST_WAKE_SIG   = fcl_pkg::FCL_WAKE_DELAY_SIGNATURE_CYC;

  // ---------------- link domain ----------------
  fcl_pkg::fcl_link_flags_t ref_flags_q;
  fcl_pkg::fcl_link_flags_t link_flags;
  fcl_pkg::fcl_link_flags_t link_flags_q;
  fcl_pkg::fcl_out_mode_t   mode_q;
  fcl_pkg::fcl_out_mode_t   next_mode;
  logic                     frame_rst;
  logic [5:0]               cnt_q;
  logic [7:0]               shin_q;
  logic [7:0]               op_val;
  logic                     op_last;
  logic [5:0]               start_cnt;
  logic [5:0]               sig_done_cnt;
  logic                     addr_lsb_q;
  logic [7:0]               cmd_q;
  logic                     cmd_tgl_q;
  logic                     sig_seen_q;
  logic [47:0]              sr_q;
  logic [47:0]              pattern;
  logic [47:0]              sr_src;
  logic [47:0]              sr_next;

  // frame state clears while chip select is high
  assign frame_rst = cs_n_in | reset_in;

  // flags frozen at select fall: the link clock idles between frames,
  // so a sync on it would lag a mode change by a frame; flags only
  // move while select is high, hence one capture per frame is safe
  always_ff @(negedge cs_n_in or posedge reset_in) begin
    if (reset_in) begin
      link_flags_q <= '0;
    end else begin
      link_flags_q <= ref_flags_q;
    end
  end
  assign link_flags = link_flags_q;

  // opcode length by mode, upper lines ignored in single-line mode
  assign op_last = link_flags.quad ?
                   (cnt_q == fcl_pkg::FCL_QUAD_OP_CLKS - 6'h01) :
                   (cnt_q == fcl_pkg::FCL_SPI_OP_CLKS - 6'h01);
  assign op_val  = link_flags.quad ? {shin_q[3:0], sio_in} :
                                     {shin_q[6:0], sio_in[0]};

  always_comb begin
    next_mode = fcl_pkg::FCL_OUT_NONE;
    if (!link_flags.busy) begin
      unique case (op_val)
        fcl_pkg::FCL_IDENTITY_READ_CMD: begin
          if (!link_flags.quad && !link_flags.deep_sleep) begin
            next_mode = fcl_pkg::FCL_OUT_IDENT;
          end
        end
        fcl_pkg::FCL_QUAD_IDENTITY_CMD: begin
          if (link_flags.quad && !link_flags.deep_sleep) begin
            next_mode = fcl_pkg::FCL_OUT_QIDENT;
          end
        end
        fcl_pkg::FCL_MAKER_DEVICE_ID_CMD: begin
          if (!link_flags.deep_sleep) begin
            next_mode = fcl_pkg::FCL_OUT_MAKER;
          end
        end
        // signature allowed even in deep sleep
        fcl_pkg::FCL_WAKE_CMD: begin
          next_mode = fcl_pkg::FCL_OUT_SIG;
        end
        default: begin
          next_mode = fcl_pkg::FCL_OUT_NONE;
        end
      endcase
    end
  end

  always_comb begin
    if (mode_q == fcl_pkg::FCL_OUT_IDENT ||
        mode_q == fcl_pkg::FCL_OUT_QIDENT) begin
      start_cnt = link_flags.quad ? fcl_pkg::FCL_QUAD_OP_CLKS :
                                    fcl_pkg::FCL_SPI_OP_CLKS;
    end else begin
      start_cnt = link_flags.quad ?
        fcl_pkg::FCL_QUAD_OP_CLKS + fcl_pkg::FCL_QUAD_ADDR_CLKS :
        fcl_pkg::FCL_SPI_OP_CLKS + fcl_pkg::FCL_SPI_ADDR_CLKS;
    end
    sig_done_cnt = start_cnt - 6'h01 + (link_flags.quad ?
      fcl_pkg::FCL_QUAD_BYTE_CLKS : fcl_pkg::FCL_SPI_BYTE_CLKS);
  end

  // bits taken on rising clock, MSB first
  always_ff @(posedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q  <= 6'h00;
      shin_q <= 8'h00;
    end else begin
      shin_q <= op_val;
      // saturate so a long burst never reloads the pattern
      if (cnt_q != fcl_pkg::FCL_CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      mode_q     <= fcl_pkg::FCL_OUT_NONE;
      addr_lsb_q <= 1'b0;
    end else begin
      if (op_last) begin
        mode_q <= next_mode;
      end
      // last address bit picks the byte order
      if (mode_q == fcl_pkg::FCL_OUT_MAKER &&
          cnt_q == start_cnt - 6'h01) begin
        addr_lsb_q <= sio_in[0];
      end
    end
  end

  // opcode stays put until the next frame, so the toggle covers it
  always_ff @(posedge sclk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_q      <= 8'h00;
      cmd_tgl_q  <= 1'b0;
      sig_seen_q <= 1'b0;
    end else if (op_last) begin
      cmd_q      <= op_val;
      cmd_tgl_q  <= ~cmd_tgl_q;
      sig_seen_q <= 1'b0;
    end else if (mode_q == fcl_pkg::FCL_OUT_SIG &&
                 cnt_q == sig_done_cnt) begin
      // one whole signature byte has gone out
      sig_seen_q <= 1'b1;
    end
  end

  always_comb begin
    unique case (mode_q)
      fcl_pkg::FCL_OUT_MAKER: begin
        // address bit selects which code leads
        pattern = addr_lsb_q ?
          {3{DEVICE_ID, MAKER_ID}} : {3{MAKER_ID, DEVICE_ID}};
      end
      fcl_pkg::FCL_OUT_SIG: begin
        pattern = {6{SIGNATURE_ID}};
      end
      default: begin
        pattern = {2{MAKER_ID, MEM_TYPE, MEM_DENSITY}};
      end
    endcase
  end

  assign sr_src  = (cnt_q == start_cnt) ? pattern : sr_q;
  assign sr_next = link_flags.quad ? {sr_src[43:0], sr_src[47:44]} :
                                     {sr_src[46:0], sr_src[47]};

  // falling edge output, rotating for repetition
  always_ff @(negedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      sr_q         <= 48'h0;
      sio_out      <= 4'h0;
      sio_oe_n_out <= fcl_pkg::FCL_OE_N_IDLE;
    end else if (mode_q != fcl_pkg::FCL_OUT_NONE &&
                 (cnt_q == start_cnt ||
                  sio_oe_n_out != fcl_pkg::FCL_OE_N_IDLE)) begin
      // quad output uses all four lines
      sr_q <= sr_next;
      if (link_flags.quad) begin
        sio_out      <= sr_src[47:44];
        sio_oe_n_out <= fcl_pkg::FCL_OE_N_QUAD;
      end else begin
        sio_out      <= {2'b00, sr_src[47], 1'b0};
        sio_oe_n_out <= fcl_pkg::FCL_OE_N_SPI;
      end
    end
  end

  // ---------------- reference domain ----------------
  logic [3:0] ref_sync;
  logic       cs_hi_s;
  logic       tgl_s;
  logic       sig_s;
  logic       clr_n_s;
  logic       tgl_seen_q;
  logic       pending_q;
  logic       exec;
  logic       act;
  logic       is_change;
  logic       is_wel_only;
  logic       arm_q;
  localparam int FCL_WAKE_W = fcl_pkg::FCL_WAKE_CNT_W;
  logic [FCL_WAKE_W-1:0] wake_cnt_q;

  fcl_sync #(
    .W (4)
  ) u_ref_sync (
    .clk_in   (ref_clk_in),
    .reset_in (reset_in),
    .d_in     ({cs_n_in, cmd_tgl_q, sig_seen_q, clear_n_in}),
    .q_out    (ref_sync)
  );
  assign {cs_hi_s, tgl_s, sig_s, clr_n_s} = ref_sync;

  // command acts once its frame has closed
  assign exec = pending_q & cs_hi_s;
  // only wake passes while in deep sleep
  assign act  = exec & (~deep_sleep_out | (cmd_q == fcl_pkg::FCL_WAKE_CMD));
  assign is_change = cmd_q inside {PAGE_WRITE_CMD, QUAD_PAGE_WRITE_CMD,
    SMALL_WIPE_CMD, HALF_BLOCK_WIPE_CMD, fcl_pkg::FCL_BLOCK_WIPE_CMD,
    fcl_pkg::FCL_CHIP_WIPE_A_CMD, fcl_pkg::FCL_CHIP_WIPE_B_CMD,
    fcl_pkg::FCL_STATUS_WRITE_CMD};
  assign is_wel_only = cmd_q inside {fcl_pkg::FCL_WRITE_DISARM_CMD,
    fcl_pkg::FCL_SECURITY_WRITE_CMD, fcl_pkg::FCL_PROTECT_SELECT_CMD,
    fcl_pkg::FCL_GANG_LOCK_CMD, fcl_pkg::FCL_GANG_UNLOCK_CMD,
    fcl_pkg::FCL_LOCK_WRITE_CMD, fcl_pkg::FCL_PROT_BIT_PROGRAM_CMD,
    fcl_pkg::FCL_PROT_BIT_ERASE_CMD, fcl_pkg::FCL_DYN_PROTECT_WRITE_CMD};

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tgl_seen_q <= 1'b0;
      pending_q  <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
      pending_q  <= (tgl_s != tgl_seen_q) | (pending_q & ~cs_hi_s);
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ref_flags_q <= '0;
    end else begin
      ref_flags_q <= '{busy: array_busy_in, deep_sleep: deep_sleep_out,
                       quad: quad_mode_in};
    end
  end

  // any other command drops the restart arm
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      arm_q <= 1'b0;
    end else if (!clr_n_s) begin
      arm_q <= 1'b0;
    end else if (act) begin
      arm_q <= (cmd_q == fcl_pkg::FCL_SOFT_RESTART_ARM_CMD);
    end
  end

  // completions and clear pin drop the latch
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      write_enable_latch_out <= 1'b0;
    end else if (!clr_n_s) begin
      write_enable_latch_out <= 1'b0;
    end else if (act && cmd_q == fcl_pkg::FCL_WRITE_ARM_CMD) begin
      // set wins over a same-cycle completion
      write_enable_latch_out <= 1'b1;
    end else if (array_done_in || (act && (is_wel_only ||
                 ((cmd_q == fcl_pkg::FCL_SUSPEND_A_CMD ||
                   cmd_q == fcl_pkg::FCL_SUSPEND_B_CMD) &&
                  !factory_boost_out) ||
                 (cmd_q == fcl_pkg::FCL_SOFT_RESTART_CMD && arm_q)))) begin
      // disarm is in the clearing set
      write_enable_latch_out <= 1'b0;
    end
  end

  // op completion or restart ends factory mode
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      factory_boost_out <= 1'b0;
    end else if (!clr_n_s) begin
      factory_boost_out <= 1'b0;
    end else if (act && cmd_q == fcl_pkg::FCL_FACTORY_BOOST_ARM_CMD) begin
      factory_boost_out <= 1'b1;
    end else if (array_done_in ||
                 (act && cmd_q == fcl_pkg::FCL_SOFT_RESTART_CMD && arm_q))
    begin
      factory_boost_out <= 1'b0;
    end
  end

  // launches toward the array and the rest of the device
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      array_start_out  <= 1'b0;
      array_cmd_out    <= 8'h00;
      suspend_out      <= 1'b0;
      soft_restart_out <= 1'b0;
    end else begin
      // no latch or busy array, no launch
      array_start_out  <= act & is_change & write_enable_latch_out &
                          ~array_busy_in & clr_n_s;
      if (act && is_change) begin
        array_cmd_out <= cmd_q;
      end
      suspend_out      <= act & ~factory_boost_out &
                          (cmd_q == fcl_pkg::FCL_SUSPEND_A_CMD ||
                           cmd_q == fcl_pkg::FCL_SUSPEND_B_CMD);
      soft_restart_out <= act & arm_q &
                          (cmd_q == fcl_pkg::FCL_SOFT_RESTART_CMD);
    end
  end

  // clear pin also ends deep sleep
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      deep_sleep_out <= 1'b0;
    end else if (!clr_n_s) begin
      deep_sleep_out <= 1'b0;
    end else if (act && !array_busy_in) begin
      if (cmd_q == fcl_pkg::FCL_DEEP_SLEEP_CMD) begin
        deep_sleep_out <= 1'b1;
      end else if (cmd_q == fcl_pkg::FCL_WAKE_CMD) begin
        deep_sleep_out <= 1'b0;
      end
    end
  end

  // wake delay counted only out of deep sleep
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wake_cnt_q <= '0;
      ready_out  <= 1'b1;
    end else if (!clr_n_s) begin
      wake_cnt_q <= '0;
      ready_out  <= 1'b1;
    end else if (act && !array_busy_in && deep_sleep_out &&
                 cmd_q == fcl_pkg::FCL_WAKE_CMD) begin
      // signature read picks the other delay
      wake_cnt_q <= sig_s ?
        FCL_WAKE_W'(fcl_pkg::FCL_WAKE_DELAY_SIGNATURE_CYC) :
        FCL_WAKE_W'(fcl_pkg::FCL_WAKE_DELAY_PLAIN_CYC);
      ready_out  <= 1'b0;
    end else if (wake_cnt_q != '0) begin
      wake_cnt_q <= wake_cnt_q - FCL_WAKE_W'(1);
      ready_out  <= (wake_cnt_q == FCL_WAKE_W'(1));
    end
  end

  // ---------------- checks ----------------
  sequence s_wake_plain;
    act && !array_busy_in && deep_sleep_out && clr_n_s && !sig_s &&
    cmd_q == fcl_pkg::FCL_WAKE_CMD;
  endsequence

  sequence s_wake_sig;
    act && !array_busy_in && deep_sleep_out && clr_n_s && sig_s &&
    cmd_q == fcl_pkg::FCL_WAKE_CMD;
  endsequence

  AST_WAKE_PLAIN_DELAY: assert property (
    @(posedge ref_clk_in) disable iff (reset_in || !clr_n_s)
    s_wake_plain |=> !ready_out ##[AST_WAKE_PLAIN:AST_WAKE_PLAIN] ready_out)
    else $error("plain wake delay wrong");

  AST_WAKE_SIG_DELAY: assert property (
    @(posedge ref_clk_in) disable iff (reset_in || !clr_n_s)
    s_wake_sig |=> !ready_out ##[AST_WAKE_SIG:AST_WAKE_SIG] ready_out)
    else $error("signature wake delay wrong");

  AST_WRITE_ARM_SETS: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    act && clr_n_s && cmd_q == fcl_pkg::FCL_WRITE_ARM_CMD
    |=> write_enable_latch_out)
    else $error("write arm did not set latch");

  AST_WRITE_DISARM_CLEARS: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    act && cmd_q == fcl_pkg::FCL_WRITE_DISARM_CMD
    |=> !write_enable_latch_out)
    else $error("write disarm did not clear latch");

  AST_CLEAR_PIN: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !clr_n_s |=> !write_enable_latch_out && !deep_sleep_out &&
                 !factory_boost_out)
    else $error("clear pin did not clear state");

  AST_NO_LATCH_NO_LAUNCH: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !write_enable_latch_out |=> !array_start_out)
    else $error("change launched without latch");

  AST_SUSPEND_REFUSED: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    factory_boost_out |=> !suspend_out)
    else $error("suspend accepted in factory mode");

  AST_FACTORY_ENDS: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    array_done_in && !(act &&
      cmd_q == fcl_pkg::FCL_FACTORY_BOOST_ARM_CMD)
    |=> !factory_boost_out)
    else $error("factory flag survived completion");

  AST_RESTART_NEEDS_ARM: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    act && cmd_q == fcl_pkg::FCL_SOFT_RESTART_CMD && !arm_q
    |=> !soft_restart_out)
    else $error("restart ran without arm");

  AST_IDENT_BUSY: assert property (
    @(posedge sclk_in) disable iff (frame_rst)
    op_last && link_flags.busy |=> mode_q == fcl_pkg::FCL_OUT_NONE)
    else $error("identity decoded while busy");

  AST_IDENT_SINGLE_ONLY: assert property (
    @(posedge sclk_in) disable iff (frame_rst)
    op_last && link_flags.quad |=> mode_q != fcl_pkg::FCL_OUT_IDENT)
    else $error("identity read decoded in quad mode");

endmodule : fcl_cmd_core
`default_nettype wire

// ---- sim/fcl_host_model.sv ----
// host controller model driving the serial link
`timescale 1ns/100ps
`default_nettype none
module fcl_host_model (
  // link towards the device
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic      [3:0] sio_out,
  input  wire logic [3:0] sio_in
);
  // clock still, select high when idle
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sio_out  = 4'h0;
  end
  task automatic xfer(input logic [31:0] tx, input int ntx, nrx,
                      input bit q, output logic [31:0] rx);
    rx = '0;
    cs_n_out = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      // idle lanes toggle so they must be ignored
      if (i < ntx)
        sio_out = q ? tx[31:28] : {~sio_out[3:1], tx[31]};
      else
        sio_out = ~sio_out;
      tx = q ? tx << 4 : tx << 1;
      #62.5 sclk_out = 1'b1;
      rx = q ? {rx[27:0], sio_in} : {rx[30:0], sio_in[1]};
      #62.5 sclk_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    // released lanes must not keep the last value
    sio_out = ~sio_out;
    #400;
  endtask : xfer
endmodule : fcl_host_model
`default_nettype wire

// ---- sim/tb_flash_cmd_latch_id_wake.sv ----
// self-checking bench for the flash command latch block
`timescale 1ns/100ps
`default_nettype none
module tb_flash_cmd_latch_id_wake;
  // arbitrary identity values
  localparam logic [7:0] MK = 8'h5A;
  localparam logic [7:0] MT = 8'h3C;
  localparam logic [7:0] MD = 8'h4E;
  localparam logic [7:0] DV = 8'h4D;
  localparam logic [7:0] SG = 8'h6B;
  localparam int PL = fcl_pkg::FCL_WAKE_DELAY_PLAIN_CYC;
  localparam int SC = fcl_pkg::FCL_WAKE_DELAY_SIGNATURE_CYC;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, clear_n_in = 1'b1;
  logic quad_mode_in = 1'b0, array_done_in = 1'b0, busy = 1'b0;
  logic sclk, cs_n, start, sus, rst_p, write_enable_latch, boost, ds, rdy;
  logic [3:0] h_sio, c_sio, oe_n, sio_w;
  logic [7:0] acmd;
  logic [31:0] rx;
  int err_count = 0;
  int n_checks = 0;
  int cnt [3] = '{0, 0, 0};
  int n_oe = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  // lane level from the core's enables: core where enabled, host elsewhere
  assign sio_w = (c_sio & ~oe_n) | (h_sio & oe_n);
  always @(posedge ref_clk_in) begin
    cnt[0] <= cnt[0] + int'(start);
    cnt[1] <= cnt[1] + int'(sus);
    cnt[2] <= cnt[2] + int'(rst_p);
  end
  always @(posedge sclk) n_oe <= n_oe + int'(oe_n !== 4'hF);
  fcl_cmd_core #(.MAKER_ID(MK), .MEM_TYPE(MT), .MEM_DENSITY(MD),
    .DEVICE_ID(DV), .SIGNATURE_ID(SG)) fcl_cmd_core_i (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .sio_in(sio_w), .sio_out(c_sio),
    .sio_oe_n_out(oe_n), .clear_n_in(clear_n_in),
    .array_busy_in(busy), .array_done_in(array_done_in),
    .quad_mode_in(quad_mode_in), .array_start_out(start),
    .array_cmd_out(acmd), .suspend_out(sus), .soft_restart_out(rst_p),
    .write_enable_latch_out(write_enable_latch), .factory_boost_out(boost),
    .deep_sleep_out(ds), .ready_out(rdy));
  fcl_host_model fcl_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n),
    .sio_out(h_sio), .sio_in(sio_w));

  task automatic chk(input logic [31:0] got, want, input string what);
    n_checks++;
    if (got !== want) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, want, got);
    end
  endtask : chk

  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic xf(input logic [7:0] c, input logic [23:0] a,
                    input int ntx, nrx, input bit q);
    fcl_host_model_i.xfer({c, a}, ntx, nrx, q, rx);
  endtask : xf

  task automatic op(input logic [7:0] c, input bit q);
    xf(c, 24'h0, q ? 2 : 8, 0, q);
  endtask : op

  task automatic ref_set(input bit q, b);
    @(posedge ref_clk_in);
    quad_mode_in <= q;
    busy <= b;
    repeat (3) @(posedge ref_clk_in);
  endtask : ref_set

  task automatic wake_wait(input int lo, hi);
    int n;
    n = 0;
    chk(rdy, 1'b0, "ready_low");
    // select stays high through the wake delay
    while (rdy !== 1'b1 && n < 400) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(n > lo && n <= hi, 1'b1, "wake_time");
    if (n >= 400) report_and_stop();
  endtask : wake_wait

  task automatic s_latch;
    for (int q = 0; q < 2; q++) begin
      ref_set(q[0], 1'b0);
      op(fcl_pkg::FCL_WRITE_ARM_CMD, q[0]);
      chk(write_enable_latch, 1'b1, "latch_set");
      op(fcl_pkg::FCL_WRITE_DISARM_CMD, q[0]);
      chk(write_enable_latch, 1'b0, "latch_clear");
    end
  endtask : s_latch

  task automatic s_ident;
    int b;
    ref_set(1'b0, 1'b0);
    xf(fcl_pkg::FCL_IDENTITY_READ_CMD, 24'h0, 8, 32, 1'b0);
    chk(rx, {MK, MT, MD, MK}, "ident");
    for (int a = 0; a < 2; a++) begin
      xf(fcl_pkg::FCL_MAKER_DEVICE_ID_CMD, 24'(a), 32, 32, 1'b0);
      chk(rx, a ? {DV, MK, DV, MK} : {MK, DV, MK, DV}, "mk_dev");
    end
    b = n_oe;
    ref_set(1'b0, 1'b1);
    xf(fcl_pkg::FCL_IDENTITY_READ_CMD, 24'h0, 8, 16, 1'b0);
    chk(n_oe - b, 0, "ident_busy");
    ref_set(1'b1, 1'b0);
    xf(fcl_pkg::FCL_IDENTITY_READ_CMD, 24'h0, 2, 8, 1'b1);
    chk(n_oe - b, 0, "ident_quad");
    xf(fcl_pkg::FCL_QUAD_IDENTITY_CMD, 24'h0, 2, 6, 1'b1);
    chk(rx[23:0], {MK, MT, MD}, "quad_ident");
    ref_set(1'b0, 1'b0);
  endtask : s_ident

  task automatic s_sleep;
    op(fcl_pkg::FCL_DEEP_SLEEP_CMD, 1'b0);
    op(fcl_pkg::FCL_WAKE_CMD, 1'b0);
    chk(ds, 1'b0, "wake");
    wake_wait(SC, PL);
    op(fcl_pkg::FCL_DEEP_SLEEP_CMD, 1'b0);
    xf(fcl_pkg::FCL_WAKE_CMD, 24'h0, 32, 16, 1'b0);
    chk(rx[15:0], {SG, SG}, "signature");
    wake_wait(0, SC);
    op(fcl_pkg::FCL_WRITE_ARM_CMD, 1'b0);
    op(fcl_pkg::FCL_DEEP_SLEEP_CMD, 1'b0);
    chk(ds, 1'b1, "sleep");
    @(posedge ref_clk_in);
    clear_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    clear_n_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    chk({ds, write_enable_latch}, 2'h0, "clear_pin");
  endtask : s_sleep

  task automatic s_boost;
    int b;
    // arm, boost arm, refused suspend, then one change
    op(fcl_pkg::FCL_WRITE_ARM_CMD, 1'b0);
    op(fcl_pkg::FCL_FACTORY_BOOST_ARM_CMD, 1'b0);
    b = cnt[1];
    op(fcl_pkg::FCL_SUSPEND_A_CMD, 1'b0);
    chk(cnt[1] - b, 0, "suspend_refused");
    b = cnt[0];
    xf(fcl_pkg::FCL_BLOCK_WIPE_CMD, 24'h0, 32, 0, 1'b0);
    chk(cnt[0] - b, 1, "wipe_start");
    chk(acmd, fcl_pkg::FCL_BLOCK_WIPE_CMD, "wipe_cmd");
    @(posedge ref_clk_in);
    array_done_in <= 1'b1;
    @(posedge ref_clk_in);
    array_done_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk({boost, write_enable_latch}, 2'h0, "done_clears");
    b = cnt[1];
    op(fcl_pkg::FCL_SUSPEND_B_CMD, 1'b0);
    chk(cnt[1] - b, 1, "suspend_ok");
    b = cnt[0];
    xf(fcl_pkg::FCL_BLOCK_WIPE_CMD, 24'h0, 32, 0, 1'b0);
    chk(cnt[0] - b, 0, "wipe_no_latch");
    b = cnt[2];
    op(fcl_pkg::FCL_SOFT_RESTART_ARM_CMD, 1'b0);
    op(fcl_pkg::FCL_SOFT_RESTART_CMD, 1'b0);
    op(fcl_pkg::FCL_SOFT_RESTART_ARM_CMD, 1'b0);
    op(fcl_pkg::FCL_WRITE_ARM_CMD, 1'b0);
    op(fcl_pkg::FCL_SOFT_RESTART_CMD, 1'b0);
    chk(cnt[2] - b, 1, "restart");
  endtask : s_boost

  initial begin
    repeat (6) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    s_latch();
    s_ident();
    s_sleep();
    s_boost();
    report_and_stop();
  end

  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end
endmodule : tb_flash_cmd_latch_id_wake
`default_nettype wire
